// >>> hw/sswd_core.sv
/*
  slave state machine with process data and local interface watchdogs
  assumes strobes and event inputs synchronous to ref_clk
*/
// Overview of operation
// - two independent watchdogs, process data and local interface, default 100 ms
// - process data watchdog restarts only on a successful process data exchange
// - expired process data watchdog forces all outputs to zero
// - watchdog expiry never changes the operating state
// - local interface watchdog expires without local accesses for its timeout
// - one shared multiplier, separate timeout counts per watchdog
// - one tick lasts multiplier plus two periods of 40 ns
// - multiplier resets to 2498, tick of 100 us
// - process data count resets to 1000, timeout of 100 ms
// - timeout count 0 to 65535, multiplier 1 to 65535
// - timeout count zero disables the process data watchdog entirely
// - power-on enters init, refusing mailbox and process data traffic
// - mailbox setup checked entering configuring; mailbox allowed from configuring through running
// - channel and clock sync checked, status shows held code during the input copy, held state entered after it
// - outputs held state allows all traffic but keeps outputs safe
// - running state drives outputs from received output data
// - firmware update only from init, file transfer mailbox only
// - with watchdog disabled outputs may be driven in outputs held state
`timescale 1ns/10ps
`include "sswd_map.svh"
module sswd_core #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 8
) (
  input  wire logic              ref_clk,
  input  wire logic              arst_n,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  input  wire logic              pd_exchange_ok,
  input  wire logic              li_access,
  input  wire logic              mbx_cfg_ok,
  input  wire logic              pd_cfg_ok,
  input  wire logic              dc_cfg_ok,
  input  wire logic              input_copy_done,
  output logic                   input_copy_req,
  input  wire logic [DATA_W-1:0] out_data_in,
  output logic      [DATA_W-1:0] out_pins,
  output logic                   mbx_allow,
  output logic                   pd_allow,
  output logic                   xfer_only,
  output logic      [1:0]        wd_expired
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  localparam logic [17:0] ACC_STEP = 18'(`SSWD_REF_NS / `SSWD_UNIT_NS);
  localparam logic [17:0] ACC_BASE = 18'(`SSWD_BASE_NS / `SSWD_UNIT_NS);

  sswd_pkg::sswd_state_t state_reg;
  logic [3:0]        req_reg;
  logic              manual_reg;
  logic              err_reg;
  logic [15:0]       mult_reg;
  logic [15:0]       tmo_reg [2];
  logic [15:0]       cnt_reg [2];
  logic [1:0]        exp_reg;
  logic [17:0]       acc_reg;
  logic              tick_reg;
  logic [31:0]       rdata_reg;
  logic [DATA_W-1:0] out_reg;
  logic [17:0]       acc_thr;
  logic [17:0]       acc_sum;
  logic [1:0]        evt;
  logic [3:0]        cur_code;
  logic              wr_ctrl;
  logic              set_ok;
  logic              drive;
  logic              pd_en;

  function automatic logic [3:0] code_of(sswd_pkg::sswd_state_t s);
    case (s)
      sswd_pkg::st_init:   code_of = `SSWD_REQ_INIT;
      sswd_pkg::st_config: code_of = `SSWD_REQ_CONFIG;
      sswd_pkg::st_boot:   code_of = `SSWD_REQ_BOOT;
      sswd_pkg::st_run:    code_of = `SSWD_REQ_RUN;
      default:             code_of = `SSWD_REQ_HELD;
    endcase
  endfunction

  assign cur_code = code_of(state_reg);
  assign wr_ctrl  = reg_wr && (reg_addr == ADDR_W'(`SSWD_OFS_CTRL));
  assign set_ok   = manual_reg && (state_reg == sswd_pkg::st_init);
  assign pd_en    = (tmo_reg[0] != 16'h0000);

  // ----------------------------------------
  // traffic gating by state
  // ----------------------------------------
  assign mbx_allow = (state_reg == sswd_pkg::st_config) || (state_reg == sswd_pkg::st_copy)
                   || pd_allow;
  assign pd_allow  = (state_reg == sswd_pkg::st_held) || (state_reg == sswd_pkg::st_run);
  assign xfer_only = (state_reg == sswd_pkg::st_boot);
  assign input_copy_req = (state_reg == sswd_pkg::st_copy);
  assign out_pins   = out_reg;
  assign wd_expired = exp_reg;
  assign reg_rdata  = rdata_reg;

  // ----------------------------------------
  // control register
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      req_reg    <= `SSWD_REQ_INIT;
      manual_reg <= 1'b0;
    end else if (wr_ctrl) begin
      req_reg    <= reg_wdata[`SSWD_CTRL_REQ_MSB:0];
      manual_reg <= reg_wdata[`SSWD_CTRL_MANUAL];
    end
  end

  // ----------------------------------------
  // watchdog settings
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mult_reg   <= `SSWD_MULT_RST;
      tmo_reg[0] <= `SSWD_PD_TMO_RST;
      tmo_reg[1] <= `SSWD_LI_TMO_RST;
    end else if (reg_wr && set_ok) begin
      if (reg_addr == ADDR_W'(`SSWD_OFS_MULT) && reg_wdata[15:0] != 16'h0000) begin
        mult_reg <= reg_wdata[15:0];
      end else if (reg_addr == ADDR_W'(`SSWD_OFS_PD_TMO)) begin
        tmo_reg[0] <= reg_wdata[15:0];
      end else if (reg_addr == ADDR_W'(`SSWD_OFS_LI_TMO)) begin
        tmo_reg[1] <= reg_wdata[15:0];
      end
    end
  end

  // ----------------------------------------
  // shared prescaler
  // ----------------------------------------
  // accumulates in 20 ns units so a 100 ns clock gives exact 40 ns multiples
  assign acc_thr = 18'({2'b00, mult_reg} + 18'h00002) * ACC_BASE;
  assign acc_sum = acc_reg + ACC_STEP;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_reg  <= 18'h00000;
      tick_reg <= 1'b0;
    end else if (acc_sum >= acc_thr) begin
      acc_reg  <= (acc_sum - acc_thr >= acc_thr) ? 18'h00000 : acc_sum - acc_thr;
      tick_reg <= 1'b1;
    end else begin
      acc_reg  <= acc_sum;
      tick_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // watchdog counters
  // ----------------------------------------
  assign evt[0] = pd_exchange_ok && pd_allow;
  assign evt[1] = li_access;

  for (genvar i = 0; i < 2; i++) begin : g_wd
    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        cnt_reg[i] <= `SSWD_PD_TMO_RST;
        exp_reg[i] <= 1'b0;
      end else begin
        if (evt[i]) begin
          cnt_reg[i] <= tmo_reg[i];
        end else if (tick_reg && cnt_reg[i] != 16'h0000) begin
          cnt_reg[i] <= cnt_reg[i] - 16'h0001;
        end
        exp_reg[i] <= (tmo_reg[i] != 16'h0000) && (cnt_reg[i] == 16'h0000) && !evt[i];
      end
    end
  end

  // ----------------------------------------
  // slave state machine
  // ----------------------------------------
  // expiry is not an input here, so the state is never touched by it
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= sswd_pkg::st_init;
      err_reg   <= 1'b0;
    end else if (wr_ctrl) begin
      err_reg <= 1'b0;
    end else if (state_reg == sswd_pkg::st_copy) begin
      if (input_copy_done) begin
        state_reg <= sswd_pkg::st_held;
      end
    end else if (!err_reg && cur_code != req_reg) begin
      case (state_reg)
        sswd_pkg::st_init: begin
          if (req_reg == `SSWD_REQ_CONFIG && mbx_cfg_ok) begin
            state_reg <= sswd_pkg::st_config;
          end else if (req_reg == `SSWD_REQ_BOOT) begin
            state_reg <= sswd_pkg::st_boot;
          end else begin
            err_reg <= 1'b1;
          end
        end
        sswd_pkg::st_config: begin
          if (req_reg == `SSWD_REQ_INIT) begin
            state_reg <= sswd_pkg::st_init;
          end else if (req_reg == `SSWD_REQ_HELD && pd_cfg_ok && dc_cfg_ok) begin
            state_reg <= sswd_pkg::st_copy;
          end else begin
            err_reg <= 1'b1;
          end
        end
        sswd_pkg::st_held: begin
          if (req_reg == `SSWD_REQ_INIT) begin
            state_reg <= sswd_pkg::st_init;
          end else if (req_reg == `SSWD_REQ_CONFIG) begin
            state_reg <= sswd_pkg::st_config;
          end else if (req_reg == `SSWD_REQ_RUN) begin
            state_reg <= sswd_pkg::st_run;
          end else begin
            err_reg <= 1'b1;
          end
        end
        sswd_pkg::st_run: begin
          if (req_reg == `SSWD_REQ_INIT) begin
            state_reg <= sswd_pkg::st_init;
          end else if (req_reg == `SSWD_REQ_CONFIG) begin
            state_reg <= sswd_pkg::st_config;
          end else if (req_reg == `SSWD_REQ_HELD) begin
            state_reg <= sswd_pkg::st_held;
          end else begin
            err_reg <= 1'b1;
          end
        end
        sswd_pkg::st_boot: begin
          if (req_reg == `SSWD_REQ_INIT) begin
            state_reg <= sswd_pkg::st_init;
          end else begin
            err_reg <= 1'b1;
          end
        end
        default: begin
          state_reg <= sswd_pkg::st_init;
        end
      endcase
    end
  end

  // ----------------------------------------
  // output driving
  // ----------------------------------------
  always_comb begin
    drive = 1'b0;
    if (state_reg == sswd_pkg::st_run) begin
      drive = !exp_reg[0];
    end else if (state_reg == sswd_pkg::st_held) begin
      drive = !pd_en;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_reg <= '0;
    end else if (drive) begin
      out_reg <= out_data_in;
    end else begin
      out_reg <= '0;
    end
  end

  // ----------------------------------------
  // register read
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= 32'h00000000;
    end else if (!reg_rd) begin
      rdata_reg <= 32'h00000000;
    end else if (reg_addr == ADDR_W'(`SSWD_OFS_CTRL)) begin
      rdata_reg <= {27'h0000000, manual_reg, req_reg};
    end else if (reg_addr == ADDR_W'(`SSWD_OFS_STATUS)) begin
      rdata_reg <= {23'h000000, (cur_code == req_reg), exp_reg, err_reg,
                    input_copy_req, cur_code};
    end else if (reg_addr == ADDR_W'(`SSWD_OFS_MULT)) begin
      rdata_reg <= {16'h0000, mult_reg};
    end else if (reg_addr == ADDR_W'(`SSWD_OFS_PD_TMO)) begin
      rdata_reg <= {16'h0000, tmo_reg[0]};
    end else if (reg_addr == ADDR_W'(`SSWD_OFS_LI_TMO)) begin
      rdata_reg <= {16'h0000, tmo_reg[1]};
    end else begin
      rdata_reg <= 32'h00000000;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  logic [17:0] gap_reg;
  logic        seen_reg;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      gap_reg  <= 18'h00000;
      seen_reg <= 1'b0;
    end else if (reg_wr && reg_addr == ADDR_W'(`SSWD_OFS_MULT)) begin
      gap_reg  <= 18'h00000;
      seen_reg <= 1'b0;
    end else if (tick_reg) begin
      gap_reg  <= 18'h00001;
      seen_reg <= 1'b1;
    end else begin
      gap_reg  <= gap_reg + 18'h00001;
    end
  end

  property p_tick_len;
    @(posedge ref_clk) disable iff (!arst_n)
    tick_reg && seen_reg |-> (gap_reg * ACC_STEP + ACC_STEP > acc_thr)
                          && (gap_reg * ACC_STEP < acc_thr + ACC_STEP);
  endproperty
  a_tick_len: assert property (p_tick_len) else $error("tick length wrong");

  property p_mult_nz;
    @(posedge ref_clk) disable iff (!arst_n)
    mult_reg != 16'h0000;
  endproperty
  a_mult_nz: assert property (p_mult_nz) else $error("multiplier zero");

  property p_exp_safe;
    @(posedge ref_clk) disable iff (!arst_n)
    exp_reg[0] |=> out_pins == '0;
  endproperty
  a_exp_safe: assert property (p_exp_safe) else $error("outputs live after expiry");

  property p_exp_keep;
    @(posedge ref_clk) disable iff (!arst_n)
    state_reg == sswd_pkg::st_run && req_reg == `SSWD_REQ_RUN && !wr_ctrl
      && $rose(exp_reg[0]) |=> state_reg == sswd_pkg::st_run;
  endproperty
  a_exp_keep: assert property (p_exp_keep) else $error("expiry left running");

  property p_dis;
    @(posedge ref_clk) disable iff (!arst_n)
    tmo_reg[0] == 16'h0000 |=> !exp_reg[0];
  endproperty
  a_dis: assert property (p_dis) else $error("disabled watchdog expired");

  property p_reload;
    @(posedge ref_clk) disable iff (!arst_n)
    evt[0] |=> cnt_reg[0] == $past(tmo_reg[0]) && !exp_reg[0];
  endproperty
  a_reload: assert property (p_reload) else $error("no reload on exchange");

  property p_init_gate;
    @(posedge ref_clk) disable iff (!arst_n)
    state_reg == sswd_pkg::st_init |-> !mbx_allow && !pd_allow;
  endproperty
  a_init_gate: assert property (p_init_gate) else $error("traffic in init");

  property p_config_gate;
    @(posedge ref_clk) disable iff (!arst_n)
    state_reg == sswd_pkg::st_config |-> mbx_allow && !pd_allow && $past(mbx_cfg_ok
      || state_reg != sswd_pkg::st_init);
  endproperty
  a_config_gate: assert property (p_config_gate) else $error("bad configuring entry");

  property p_copy;
    @(posedge ref_clk) disable iff (!arst_n)
    state_reg == sswd_pkg::st_held && $past(state_reg) == sswd_pkg::st_config |-> 1'b0;
  endproperty
  a_copy: assert property (p_copy) else $error("held state without copy");

  property p_held;
    @(posedge ref_clk) disable iff (!arst_n)
    state_reg == sswd_pkg::st_held && pd_en ##1 state_reg == sswd_pkg::st_held
      |-> out_pins == '0;
  endproperty
  a_held: assert property (p_held) else $error("outputs live in held state");

  property p_boot;
    @(posedge ref_clk) disable iff (!arst_n)
    state_reg == sswd_pkg::st_boot |-> xfer_only && !mbx_allow && !pd_allow
      && ($past(state_reg) == sswd_pkg::st_boot || $past(state_reg) == sswd_pkg::st_init);
  endproperty
  a_boot: assert property (p_boot) else $error("bad firmware update state");

  property p_run;
    @(posedge ref_clk) disable iff (!arst_n)
    state_reg == sswd_pkg::st_run && !exp_reg[0] |=> out_pins == $past(out_data_in);
  endproperty
  a_run: assert property (p_run) else $error("outputs not driven");

  c_run: cover property (@(posedge ref_clk) disable iff (!arst_n)
    state_reg == sswd_pkg::st_run && exp_reg[0]);
  c_copy: cover property (@(posedge ref_clk) disable iff (!arst_n)
    state_reg == sswd_pkg::st_copy ##1 state_reg == sswd_pkg::st_held);
  c_boot: cover property (@(posedge ref_clk) disable iff (!arst_n)
    state_reg == sswd_pkg::st_boot);
  c_li: cover property (@(posedge ref_clk) disable iff (!arst_n) $rose(exp_reg[1]));
endmodule

// >>> inc/sswd_map.svh
/*
  register offsets, field positions, reset values and timing counts
  assumes inclusion by bare name from design and bench files
*/
`ifndef SSWD_MAP_SVH
`define SSWD_MAP_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define SSWD_OFS_CTRL     8'h00
`define SSWD_OFS_STATUS   8'h04
`define SSWD_OFS_MULT     8'h08
`define SSWD_OFS_PD_TMO   8'h0C
`define SSWD_OFS_LI_TMO   8'h10
// ----------------------------------------
// fields and state request codes
// ----------------------------------------
`define SSWD_CTRL_REQ_MSB 3
`define SSWD_CTRL_MANUAL  4
`define SSWD_REQ_INIT     4'h1
`define SSWD_REQ_CONFIG   4'h2
`define SSWD_REQ_BOOT     4'h3
`define SSWD_REQ_HELD     4'h4
`define SSWD_REQ_RUN      4'h8
// ----------------------------------------
// reset values
// ----------------------------------------
`define SSWD_MULT_RST     16'h09C2
`define SSWD_PD_TMO_RST   16'h03E8
`define SSWD_LI_TMO_RST   16'h03E8
// ----------------------------------------
// timing
// ----------------------------------------
`define SSWD_BASE_NS      40
`define SSWD_REF_NS       100
`define SSWD_UNIT_NS      20
`define SSWD_TICK_US      100
`define SSWD_WD_MS        100
`endif

// >>> inc/sswd_pkg.sv
/*
  types of the slave state watchdog block
  assumes nothing of its surroundings
*/
package sswd_pkg;
  typedef enum logic [2:0] {
    st_init,
    st_config,
    st_copy,
    st_held,
    st_run,
    st_boot
  } sswd_state_t;
endpackage

// >>> verif/sswd_partner.sv
/*
  model of the master and local processor side of the slave state watchdog
  assumes ref_clk and arst_n shared with the design
*/
`timescale 1ns/10ps
module sswd_partner (
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic       input_copy_req,
  input  wire logic [3:0] copy_delay,
  output logic            input_copy_done,
  output logic            mbx_cfg_ok,
  output logic            pd_cfg_ok,
  output logic            dc_cfg_ok
);
  logic [3:0] wait_reg;

  // ----------------------------------------
  // channel setup results
  // ----------------------------------------
  assign mbx_cfg_ok = arst_n;
  assign pd_cfg_ok  = arst_n;
  assign dc_cfg_ok  = arst_n;

  // ----------------------------------------
  // input copy answer, prompt or slow
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_reg        <= 4'h0;
      input_copy_done <= 1'b0;
    end else if (input_copy_req && !input_copy_done) begin
      if (wait_reg == copy_delay) begin
        input_copy_done <= 1'b1;
      end else begin
        wait_reg <= wait_reg + 4'h1;
      end
    end else begin
      wait_reg        <= 4'h0;
      input_copy_done <= 1'b0;
    end
  end
endmodule

// >>> verif/sswd_core_tb.sv
/*
  self-checking bench of the slave state watchdog core
  assumes the partner model and the register map header
*/
`timescale 1ns/10ps
`include "sswd_map.svh"
module sswd_core_tb;
  logic        ref_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        pd_exchange_ok = 1'b0;
  logic        li_access = 1'b0;
  logic        mbx_cfg_ok, pd_cfg_ok, dc_cfg_ok;
  logic        input_copy_done, input_copy_req;
  logic [7:0]  out_data_in = 8'h00;
  logic [7:0]  out_pins;
  logic        mbx_allow, pd_allow, xfer_only;
  logic [1:0]  wd_expired;
  logic [3:0]  copy_delay = 4'h0;
  logic        pd_run = 1'b0;
  logic        li_run = 1'b0;
  logic [31:0] st;
  int          fail_count = 0;
  int          samples_checked = 0;
  logic [7:0]  row_addr [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
  logic [31:0] row_exp  [6] = '{32'h1, 32'h101, 32'h9C2, 32'h3E8, 32'h3E8, 32'h0};

  always #50 ref_clk = ~ref_clk;

  // ----------------------------------------
  // exchange and local access pulse sources
  // ----------------------------------------
  always @(posedge ref_clk) begin
    pd_exchange_ok <= pd_run & ~pd_exchange_ok;
    li_access      <= li_run & ~li_access;
  end

  sswd_core sswd_core_i (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pd_exchange_ok(pd_exchange_ok), .li_access(li_access), .mbx_cfg_ok(mbx_cfg_ok),
    .pd_cfg_ok(pd_cfg_ok), .dc_cfg_ok(dc_cfg_ok), .input_copy_done(input_copy_done),
    .input_copy_req(input_copy_req), .out_data_in(out_data_in), .out_pins(out_pins),
    .mbx_allow(mbx_allow), .pd_allow(pd_allow), .xfer_only(xfer_only),
    .wd_expired(wd_expired));

  sswd_partner sswd_partner_i (.ref_clk(ref_clk), .arst_n(arst_n),
    .input_copy_req(input_copy_req), .copy_delay(copy_delay),
    .input_copy_done(input_copy_done), .mbx_cfg_ok(mbx_cfg_ok), .pd_cfg_ok(pd_cfg_ok),
    .dc_cfg_ok(dc_cfg_ok));

  // ----------------------------------------
  // bus, compare and wait tasks
  // ----------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 st = reg_rdata;
  endtask

  task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(n, e, st);
  endtask

  function automatic logic pick(input int w);
    case (w)
      0: return pd_allow;
      1: return wd_expired[0];
      2: return wd_expired[1];
      3: return mbx_allow;
      4: return xfer_only;
      5: return input_copy_req;
      default: return out_pins === 8'hA5;
    endcase
  endfunction

  task automatic wait_sig(input string n, input int w, input logic v);
    for (int i = 0; i < 200; i++) begin
      @(posedge ref_clk);
      #1;
      if (pick(w) === v) begin
        samples_checked++;
        return;
      end
    end
    fail_count++;
    $display("unexpected %s expected %b seen %b", n, v, pick(w));
    wrap_up();
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge ref_clk);
    arst_n <= 1'b1;
    #1 chk("reset_outputs", 32'h0, {pd_allow, mbx_allow, xfer_only, input_copy_req,
      wd_expired, out_pins});
    for (int r = 0; r < 6; r++) begin
      rdchk("reset_register", row_addr[r], row_exp[r]);
    end
    $display("test reset done");
    wr(`SSWD_OFS_CTRL, 32'h11);
    wr(`SSWD_OFS_MULT, 32'h0);
    rdchk("mult_zero_refused", `SSWD_OFS_MULT, 32'h9C2);
    wr(`SSWD_OFS_MULT, 32'h1);
    wr(`SSWD_OFS_PD_TMO, 32'h4);
    wr(`SSWD_OFS_LI_TMO, 32'h6);
    rdchk("pd_timeout", `SSWD_OFS_PD_TMO, 32'h4);
    rdchk("li_timeout", `SSWD_OFS_LI_TMO, 32'h6);
    li_run = 1'b1;
    $display("test settings done");
    wr(`SSWD_OFS_CTRL, 32'h12);
    wait_sig("mbx_allow", 3, 1'b1);
    chk("pd_allow_config", 32'h0, {31'h0, pd_allow});
    wr(`SSWD_OFS_PD_TMO, 32'h9);
    rdchk("late_setting", `SSWD_OFS_PD_TMO, 32'h4);
    out_data_in <= 8'hA5;
    copy_delay = 4'h6;
    wr(`SSWD_OFS_CTRL, 32'h14);
    wait_sig("input_copy_req", 5, 1'b1);
    wait_sig("pd_allow_held", 0, 1'b1);
    pd_run = 1'b1;
    repeat (5) @(posedge ref_clk);
    #1 chk("out_pins_held", 32'h0, {24'h0, out_pins});
    $display("test held done");
    wr(`SSWD_OFS_CTRL, 32'h18);
    wait_sig("out_pins_running", 6, 1'b1);
    pd_run = 1'b0;
    wait_sig("pd_expired", 1, 1'b1);
    chk("li_expired_early", 32'h0, {31'h0, wd_expired[1]});
    @(posedge ref_clk);
    #1 chk("out_pins_expired", 32'h0, {24'h0, out_pins});
    rd(`SSWD_OFS_STATUS);
    chk("state_after_expiry", 32'h8, {28'h0, st[3:0]});
    li_run = 1'b0;
    wait_sig("li_expired", 2, 1'b1);
    $display("test expiry done");
    wr(`SSWD_OFS_CTRL, 32'h13);
    repeat (3) @(posedge ref_clk);
    rd(`SSWD_OFS_STATUS);
    chk("refused_boot", 32'h18, {27'h0, st[5], st[3:0]});
    wr(`SSWD_OFS_CTRL, 32'h11);
    wait_sig("mbx_allow_init", 3, 1'b0);
    wr(`SSWD_OFS_CTRL, 32'h13);
    wait_sig("xfer_only", 4, 1'b1);
    chk("boot_traffic", 32'h0, {30'h0, pd_allow, mbx_allow});
    $display("test boot done");
    wr(`SSWD_OFS_CTRL, 32'h11);
    wait_sig("xfer_only_init", 4, 1'b0);
    wr(`SSWD_OFS_PD_TMO, 32'h0);
    copy_delay <= 4'h0;
    wr(`SSWD_OFS_CTRL, 32'h12);
    wait_sig("mbx_allow_again", 3, 1'b1);
    wr(`SSWD_OFS_CTRL, 32'h14);
    wait_sig("pd_allow_again", 0, 1'b1);
    repeat (30) @(posedge ref_clk);
    #1 chk("out_pins_no_watchdog", 32'hA5, {24'h0, out_pins});
    chk("pd_expired_disabled", 32'h0, {31'h0, wd_expired[0]});
    $display("test disabled watchdog done");
    wrap_up();
  end
endmodule
